// ==== pkg/lat_consts.svh ====
// Offsets, field positions, reset values and sizes of the trigger sequencer.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one word per register.
`ifndef LAT_CONSTS_SVH
`define LAT_CONSTS_SVH
`define LAT_ADDR_W 7
`define LAT_CTRL_ADDR 7'h00
`define LAT_STAT_ADDR 7'h04
`define LAT_STAGE_BASE 2'h1
`define LAT_DEC_CTRL 6'h00
`define LAT_DEC_STAT 6'h01
`define LAT_DEC_NONE 6'h1F
`define LAT_ARM_BIT 0
`define LAT_ABORT_BIT 1
`define LAT_NSTG_LO 2
`define LAT_AND_LO 4
`define LAT_PRE_LO 8
`define LAT_STAT_STG_LO 4
`define LAT_STAT_CNT_LO 16
`define LAT_CHAN_MAX 40
`define LAT_DEPTH 11'h400
`define LAT_PRE_STEP_SH 8
`define LAT_NSTG_RST 2'h1
`define LAT_AND_RST 3'h7
`define LAT_PRE_RST 2'h0
`define LAT_DC_RST 40'hFF_FFFF_FFFF
`define LAT_RESP_OKAY 2'h0
`define LAT_RESP_SLVERR 2'h2
`endif

// ==== pkg/lat_pkg.sv ====
// Types shared by the trigger sequencer: stage masks, control word, states.
// Assumes lat_consts.svh supplies the numeric constants.
package lat_pkg;
  typedef struct packed {
    logic [39:0] value;
    logic [39:0] edge_m;
    logic [39:0] dc;
  } stage_cfg_t;
  typedef struct packed {
    logic [1:0] pre_q;
    logic [2:0] and_mode;
    logic [1:0] nstg;
  } ctrl_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_POST = 2'b10,
    ST_DONE = 2'b11
  } seq_state_t;
endpackage

// ==== hw/logic_analyzer_trigger_sequencer.sv ====
// Trigger match and three-stage sequencer of an on-chip logic analyzer.
// Assumes an AXI4-Lite master on aclk and a free-running user clock pin.
// Behaviour
// - Trigger bus width parameter, one to forty
// - Post sampling starts after final stage matches
// - One stage ignores rest; two stages in order
// - Three stages match on successive later clocks
// - Pattern bit n watches trigger channel n
// - Value, edge, ignore masks give five states
// - Ignored channels never affect stage match
// - Rising and falling match on observed transitions
// - Level high matches whenever channel reads one
// - Level low matches whenever channel reads zero
// - All-ignore stage matches on first evaluation
// - AND mode needs every active channel
// - OR mode needs any active channel
// - Combining mode chosen separately per stage
// - Sample trigger on user clock rising edge
// - Depth split before and after trigger
`timescale 1ns/1ps
`include "lat_consts.svh"
module logic_analyzer_trigger_sequencer #(
  parameter int TRIG_WIDTH = 40
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic user_clk,
  input wire logic [TRIG_WIDTH-1:0] trig_in,
  output logic trigger_out,
  output logic capture_active
);
  // Channels above the build width never take part in a match
  localparam logic [39:0] CHAN_MASK = {40{1'b1}} >> (`LAT_CHAN_MAX - TRIG_WIDTH);

  function automatic logic [5:0] reg_decode(input logic [31:0] a);
    logic [5:0] d;
    d = `LAT_DEC_NONE;
    if (a[31:`LAT_ADDR_W] != 25'h0 || a[1:0] != 2'h0) begin
      d = `LAT_DEC_NONE;
    end else if (a[6:0] == `LAT_CTRL_ADDR) begin
      d = `LAT_DEC_CTRL;
    end else if (a[6:0] == `LAT_STAT_ADDR) begin
      d = `LAT_DEC_STAT;
    end else if (a[6:5] >= `LAT_STAGE_BASE && a[4:2] < 3'h6) begin
      d = {1'b1, a[6:5] - `LAT_STAGE_BASE, a[4:2]};
    end
    return d;
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Stage match: edge bit picks transition, value picks direction or level
  function automatic logic stage_match(input lat_pkg::stage_cfg_t c, input logic and_m,
                                       input logic [39:0] cur, input logic [39:0] prv,
                                       input logic pv);
    logic [39:0] act;
    logic [39:0] hit;
    act = ~c.dc & CHAN_MASK;
    hit = (c.edge_m & {40{pv}} & ((c.value & cur & ~prv) | (~c.value & ~cur & prv)))
        | (~c.edge_m & ~(cur ^ c.value));
    if (act == 40'h0) begin
      return 1'b1;
    end else if (and_m) begin
      return &(hit | ~act);
    end
    return |(hit & act);
  endfunction

  // Pin synchronisers; the user clock is sampled and its rising edge found
  logic [2:0] uclk_reg;
  logic [39:0] trig_s1_reg;
  logic [39:0] trig_s2_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uclk_reg <= 3'h0;
      trig_s1_reg <= 40'h0;
      trig_s2_reg <= 40'h0;
    end else begin
      uclk_reg <= {uclk_reg[1:0], user_clk};
      trig_s1_reg <= 40'(trig_in);
      trig_s2_reg <= trig_s1_reg;
    end
  end
  logic tick;
  assign tick = uclk_reg[1] & ~uclk_reg[2];

  // Register file and bus slave
  lat_pkg::ctrl_t ctrl_reg, ctrl_next;
  lat_pkg::stage_cfg_t cfg_reg [3];
  lat_pkg::stage_cfg_t cfg_next [3];
  logic aw_v_reg, aw_v_next, w_v_reg, w_v_next;
  logic [31:0] awaddr_reg, awaddr_next, wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic arm_cmd, abort_cmd;
  lat_pkg::seq_state_t st_reg, st_next;
  logic [1:0] stg_reg, stg_next;
  logic [10:0] pre_cnt_reg, pre_cnt_next, post_cnt_reg, post_cnt_next;

  always_comb begin
    logic [5:0] wd;
    logic [5:0] rd;
    logic [39:0] f;
    logic [31:0] w;
    wd = reg_decode(awaddr_reg);
    rd = reg_decode(s_axi_araddr);
    f = 40'h0;
    w = 32'h0;
    ctrl_next = ctrl_reg;
    cfg_next = cfg_reg;
    aw_v_next = aw_v_reg;
    w_v_next = w_v_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    arm_cmd = 1'b0;
    abort_cmd = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_v_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_v_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_v_reg && w_v_reg) begin
      aw_v_next = 1'b0;
      w_v_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `LAT_RESP_OKAY;
      if (wd == `LAT_DEC_CTRL) begin
        w = strb_merge({22'h0, ctrl_reg.pre_q, 1'b0, ctrl_reg.and_mode, ctrl_reg.nstg, 2'b00},
                       wdata_reg, wstrb_reg);
        ctrl_next.nstg = w[`LAT_NSTG_LO +: 2];
        ctrl_next.and_mode = w[`LAT_AND_LO +: 3];
        ctrl_next.pre_q = w[`LAT_PRE_LO +: 2];
        arm_cmd = wstrb_reg[0] & wdata_reg[`LAT_ARM_BIT];
        abort_cmd = wstrb_reg[0] & wdata_reg[`LAT_ABORT_BIT];
      end else if (wd[5]) begin
        case (wd[2:1])
          2'd0: f = cfg_reg[wd[4:3]].value;
          2'd1: f = cfg_reg[wd[4:3]].edge_m;
          default: f = cfg_reg[wd[4:3]].dc;
        endcase
        if (wd[0]) begin
          w = strb_merge({24'h0, f[39:32]}, wdata_reg, wstrb_reg);
          f[39:32] = w[7:0];
        end else begin
          f[31:0] = strb_merge(f[31:0], wdata_reg, wstrb_reg);
        end
        case (wd[2:1])
          2'd0: cfg_next[wd[4:3]].value = f;
          2'd1: cfg_next[wd[4:3]].edge_m = f;
          default: cfg_next[wd[4:3]].dc = f;
        endcase
      end else if (wd != `LAT_DEC_STAT) begin
        bresp_next = `LAT_RESP_SLVERR;
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = `LAT_RESP_OKAY;
      rdata_next = 32'h0;
      if (rd == `LAT_DEC_CTRL) begin
        rdata_next = {22'h0, ctrl_reg.pre_q, 1'b0, ctrl_reg.and_mode, ctrl_reg.nstg, 2'b00};
      end else if (rd == `LAT_DEC_STAT) begin
        rdata_next = {5'h0, post_cnt_reg, 10'h0, stg_reg, 1'b0, st_reg == lat_pkg::ST_DONE,
                      st_reg == lat_pkg::ST_POST, st_reg == lat_pkg::ST_ARMED};
      end else if (rd[5]) begin
        case (rd[2:1])
          2'd0: f = cfg_reg[rd[4:3]].value;
          2'd1: f = cfg_reg[rd[4:3]].edge_m;
          default: f = cfg_reg[rd[4:3]].dc;
        endcase
        rdata_next = rd[0] ? {24'h0, f[39:32]} : f[31:0];
      end else begin
        rresp_next = `LAT_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= '{pre_q: `LAT_PRE_RST, and_mode: `LAT_AND_RST, nstg: `LAT_NSTG_RST};
      for (int i = 0; i < 3; i++) begin
        cfg_reg[i] <= '{value: 40'h0, edge_m: 40'h0, dc: `LAT_DC_RST};
      end
      aw_v_reg <= 1'b0;
      w_v_reg <= 1'b0;
      awaddr_reg <= 32'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= 32'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      cfg_reg <= cfg_next;
      aw_v_reg <= aw_v_next;
      w_v_reg <= w_v_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end
  // Holding one write at a time keeps the response order trivially correct
  assign s_axi_awready = !aw_v_reg && !bvalid_reg;
  assign s_axi_wready = !w_v_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // Sequencer
  logic [39:0] prev_reg, prev_next;
  logic pv_reg, pv_next, trig_reg, trig_next;
  logic [2:0] m_vec;
  logic [1:0] last_stg;
  logic [10:0] pre_len, post_len;
  logic m_now;
  for (genvar g = 0; g < 3; g++) begin : g_stage
    assign m_vec[g] = stage_match(cfg_reg[g], ctrl_reg.and_mode[g], trig_s2_reg,
                                  prev_reg, pv_reg);
  end
  assign last_stg = (ctrl_reg.nstg == 2'h0) ? 2'h0 : ctrl_reg.nstg - 2'h1;
  assign m_now = m_vec[stg_reg];
  assign pre_len = 11'({ctrl_reg.pre_q, 8'h00});
  assign post_len = `LAT_DEPTH - pre_len;

  always_comb begin
    st_next = st_reg;
    stg_next = stg_reg;
    prev_next = prev_reg;
    pv_next = pv_reg;
    pre_cnt_next = pre_cnt_reg;
    post_cnt_next = post_cnt_reg;
    trig_next = 1'b0;
    if (abort_cmd) begin
      st_next = lat_pkg::ST_IDLE;
    end else if (arm_cmd) begin
      st_next = lat_pkg::ST_ARMED;
      stg_next = 2'h0;
      pv_next = 1'b0;
      pre_cnt_next = 11'h0;
      post_cnt_next = 11'h0;
    end else if (tick) begin
      case (st_reg)
        lat_pkg::ST_ARMED: begin
          prev_next = trig_s2_reg;
          pv_next = 1'b1;
          if (pre_cnt_reg != pre_len) begin
            pre_cnt_next = pre_cnt_reg + 11'h1;
          end
          if (m_now && stg_reg == last_stg) begin
            st_next = lat_pkg::ST_POST;
            trig_next = 1'b1;
          end else if (m_now) begin
            stg_next = stg_reg + 2'h1;
          end
        end
        lat_pkg::ST_POST: begin
          post_cnt_next = post_cnt_reg + 11'h1;
          if (post_cnt_next == post_len) begin
            st_next = lat_pkg::ST_DONE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= lat_pkg::ST_IDLE;
      stg_reg <= 2'h0;
      prev_reg <= 40'h0;
      pv_reg <= 1'b0;
      pre_cnt_reg <= 11'h0;
      post_cnt_reg <= 11'h0;
      trig_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      stg_reg <= stg_next;
      prev_reg <= prev_next;
      pv_reg <= pv_next;
      pre_cnt_reg <= pre_cnt_next;
      post_cnt_reg <= post_cnt_next;
      trig_reg <= trig_next;
    end
  end
  assign trigger_out = trig_reg;
  assign capture_active = (st_reg == lat_pkg::ST_POST);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_eval;
    st_reg == lat_pkg::ST_ARMED && tick && !arm_cmd && !abort_cmd;
  endsequence
  sequence s_final_hit;
    s_eval ##0 (m_now && stg_reg == last_stg);
  endsequence
  a_final_fires: assert property (s_final_hit |=> trigger_out && capture_active)
    else $error("final stage match did not fire");
  a_trig_pulse: assert property (trigger_out |=> !trigger_out)
    else $error("trigger pulse longer than one cycle");
  a_stage_step: assert property (s_eval ##0 (m_now && stg_reg != last_stg)
      |=> stg_reg == $past(stg_reg) + 2'h1 && !trigger_out)
    else $error("stage did not advance on match");
  a_no_match_hold: assert property (s_eval ##0 !m_now
      |=> st_reg == lat_pkg::ST_ARMED && $stable(stg_reg))
    else $error("sequencer moved without a match");
  a_all_ignore: assert property (s_eval ##0 ((cfg_reg[stg_reg].dc & CHAN_MASK) == CHAN_MASK)
      |-> m_now)
    else $error("all-ignore stage failed to match");
  a_first_no_edge: assert property (s_eval ##0 !pv_reg
      ##0 ((cfg_reg[stg_reg].dc & CHAN_MASK) == (~cfg_reg[stg_reg].edge_m & CHAN_MASK))
      ##0 ((cfg_reg[stg_reg].edge_m & CHAN_MASK) != 40'h0) |-> !m_now)
    else $error("edge reported on first sample after arming");
  a_prev_sample: assert property (s_eval |=> prev_reg == $past(trig_s2_reg) && pv_reg)
    else $error("previous sample not taken on user clock edge");
  a_post_count: assert property (st_reg == lat_pkg::ST_POST && st_next == lat_pkg::ST_DONE
      |-> post_cnt_reg + 11'h1 == post_len)
    else $error("post-trigger sample count wrong");
endmodule

// ==== tb/trig_source.sv ====
// Stand-in for the user logic: free-running user clock and trigger channels.
// Assumes the bench places the next pattern on next_pat after each user clock rise.
`timescale 1ns/1ps
module trig_source #(
  parameter int W = 8
) (
  input wire logic [W-1:0] next_pat,
  output logic user_clk,
  output logic [W-1:0] trig
);
  initial begin
    user_clk = 1'b0;
    trig = '0;
  end
  always #80 user_clk = ~user_clk;
  // Change on the falling edge so the value is settled at every sampling edge
  always @(negedge user_clk) trig <= next_pat;
endmodule

// ==== tb/test_logic_analyzer_trigger_sequencer.sv ====
// Self-checking bench of the trigger sequencer over AXI4-Lite and a trigger source.
// Assumes an 8-channel build; stage masks above channel 7 stay ignored.
`timescale 1ns/1ps
module test_logic_analyzer_trigger_sequencer;
  localparam int W = 8;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, user_clk, trigger_out, capture_active;
  logic [1:0] bresp, rresp, r, ns;
  logic [2:0] md;
  logic [W-1:0] trig, next_pat = '0;
  logic [W-1:0] sv [3], se [3], sd [3], pat [16];
  int err_count = 0, tests_run = 0, seed = 66061, ucnt = 0, base = 0, fire_at = -1;

  always #2 aclk = ~aclk;
  always @(posedge user_clk) ucnt++;
  always @(posedge aclk) if (trigger_out === 1'b1 && fire_at < 0) fire_at = ucnt - base - 1;

  logic_analyzer_trigger_sequencer #(.TRIG_WIDTH(W)) i_logic_analyzer_trigger_sequencer (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .user_clk(user_clk), .trig_in(trig), .trigger_out(trigger_out),
    .capture_active(capture_active)
  );
  trig_source #(.W(W)) i_trig_source (.next_pat(next_pat), .user_clk(user_clk), .trig(trig));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic timeout;
    err_count++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    print_verdict();
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (++n > 50) timeout();
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready && arvalid) arvalid <= 1'b0;
      if (++n > 50) timeout();
    end while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wait_ca(input logic v, input int lim);
    int n;
    n = 0;
    while (capture_active !== v) begin
      @(posedge aclk);
      if (++n > lim) timeout();
    end
  endtask

  // Tick index at which the final stage matches, or -1 when it never does
  function automatic int model(input int n);
    int st;
    logic [W-1:0] ok, c, p;
    st = 0;
    for (int k = 0; k < n; k++) begin
      c = pat[k];
      p = k > 0 ? pat[k-1] : c;
      ok = ~(c ^ sv[st]);
      ok = (se[st] & (k > 0 ? (sv[st] & c & ~p) | (~sv[st] & ~c & p) : '0)) | (~se[st] & ok);
      if ((&sd[st]) || (md[st] ? &(ok | sd[st]) : |(ok & ~sd[st]))) begin
        if (st == ns - 1) return k;
        st++;
      end
    end
    return -1;
  endfunction

  task automatic run(input int n);
    int e;
    for (int s = 0; s < 3; s++) begin
      wr(32'h20 * (s + 1), {24'h0, sv[s]}, r);
      wr(32'h20 * (s + 1) + 8, {24'h0, se[s]}, r);
      wr(32'h20 * (s + 1) + 16, {24'hFFFFFF, sd[s]}, r);
    end
    check(r, 2'h0);
    e = model(n);
    next_pat = pat[0];
    @(negedge user_clk);
    fire_at = -1;
    wr(32'h0, {22'h0, 2'h0, 1'b0, md, ns, 2'h1}, r);
    base = ucnt;
    for (int k = 1; k <= n; k++) begin
      @(posedge user_clk);
      next_pat = pat[k];
    end
    repeat (20) @(posedge aclk);
    check(fire_at, e);
    if (e >= 0) check(capture_active, 1'b1);
    else check(capture_active, 1'b0);
    wr(32'h0, 32'h2, r);
    repeat (2) @(posedge aclk);
    check(capture_active, 1'b0);
    $display("case ends, trigger at tick %0d", fire_at);
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(32'h0, d, r);
    check(d, 32'h74);
    rd(32'h38, d, r);
    check(r, 2'h2);
    rd(32'h4, d, r);
    check(d, 32'h0);
    $display("register test ends");
    for (int k = 0; k < 16; k++) pat[k] = $random(seed);
    for (int s = 0; s < 3; s++) begin
      sd[s] = '1;
      se[s] = '0;
      sv[s] = '0;
    end
    ns = 2'd3;
    md = 3'h0;
    run(12);
    // Rising on the top channel: the level seen at the first tick is not an edge
    sd[0] = 8'h7F;
    se[0] = 8'h80;
    sv[0] = 8'h80;
    ns = 2'd1;
    for (int k = 0; k < 16; k++) pat[k] = (k == 2) ? 8'h00 : 8'h80;
    run(12);
    for (int i = 0; i < 24; i++) begin
      for (int s = 0; s < 3; s++) begin
        sd[s] = $random(seed) | $random(seed);
        se[s] = $random(seed);
        sv[s] = $random(seed);
      end
      ns = 2'(1 + ($unsigned($random(seed)) % 3));
      md = $random(seed);
      // Same conditions armed twice, as a repeated capture would
      repeat (2) begin
        for (int k = 0; k < 16; k++) pat[k] = $random(seed);
        run(12);
      end
    end
    // Three quarters before the trigger leaves 256 samples after it
    // Stage one all-ignore so the static channels fire at once
    wr(32'h30, 32'hFFFFFFFF, r);
    check(r, 2'h0);
    wr(32'h0, {22'h0, 2'h3, 1'b0, 3'h7, 2'h1, 2'h1}, r);
    wait_ca(1'b1, 1000);
    wait_ca(1'b0, 20000);
    rd(32'h4, d, r);
    check(d[2], 1'b1);
    check(d[26:16], 11'd256);
    $display("depth test ends");
    print_verdict();
  end
endmodule
